// >>> core/dccbs_pkg.sv
// constants and types of the dual-channel capture and buffer timer
package dccbs_pkg;
  // ==========================================================
  // widths
  localparam int DW = 16;
  localparam int AW = 8;
  // ==========================================================
  // register offsets (channel 1 adds CH_STRIDE)
  localparam logic [7:0] CH_STRIDE = 8'h10;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_IOAB = 8'h01;
  localparam logic [7:0] OFS_IOCD = 8'h02;
  localparam logic [7:0] OFS_STS = 8'h03;
  localparam logic [7:0] OFS_CNT = 8'h04;
  localparam logic [7:0] OFS_GRA = 8'h05;
  localparam logic [7:0] OFS_FILT = 8'h09;
  localparam logic [7:0] OFS_START = 8'h20;
  localparam logic [7:0] OFS_MODE = 8'h21;
  localparam logic [7:0] OFS_FUNC = 8'h22;
  // ==========================================================
  // field positions
  localparam int CTRL_CLR_LSB = 0;
  localparam int CTRL_SRC_LSB = 3;
  localparam int CTRL_EDGE_LSB = 6;
  localparam int IO_PIN_W = 4;
  localparam int IO_CAP_BIT = 2;
  localparam int IO_AUX_BIT = 3;
  localparam int STS_OVF_BIT = 4;
  localparam int STS_UDF_BIT = 5;
  localparam int CSEL_LSB = 2;
  localparam int MODE_BFC_LSB = 1;
  localparam int MODE_BFD_LSB = 3;
  // ==========================================================
  // reset, counter clear and maximum count values
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [15:0] CLR_VALUE = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  // ==========================================================
  // encodings
  typedef enum logic [2:0] {
    FN_TIMER = 3'h0,
    FN_PWM = 3'h1,
    FN_RSYNC = 3'h2,
    FN_COMPL = 3'h3,
    FN_PWM3 = 3'h4
  } dccbs_func_t;
  localparam logic [2:0] CLR_FREE = 3'h0;
  localparam logic [2:0] CLR_GRA = 3'h1;
  localparam logic [2:0] CLR_GRB = 3'h2;
  localparam logic [2:0] CLR_SYNC = 3'h3;
  localparam logic [2:0] SRC_DIV1 = 3'h0;
  localparam logic [2:0] SRC_DIV2 = 3'h1;
  localparam logic [2:0] SRC_DIV4 = 3'h2;
  localparam logic [2:0] SRC_DIV8 = 3'h3;
  localparam logic [2:0] SRC_DIV32 = 3'h4;
  localparam logic [2:0] SRC_EXT = 3'h5;
  localparam logic [2:0] SRC_FAST = 3'h6;
endpackage : dccbs_pkg

// >>> core/dccbs_in_cond.sv
// input synchroniser, three-sample filter and edge detector
`timescale 1ns/10ps
`default_nettype none
module dccbs_in_cond (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_pin,
  input wire logic i_filter_en,
  output logic o_rise,
  output logic o_fall
);
  typedef struct packed {
    logic [1:0] sync;
    logic [2:0] samp;
    logic level;
    logic rise;
    logic fall;
  } dccbs_cond_t;
  dccbs_cond_t s_r;
  dccbs_cond_t s_nxt;
  // ==========================================================
  // next state: sync[0] feeds only sync[1]
  always_comb begin
    s_nxt = s_r;
    s_nxt.sync = {s_r.sync[0], i_pin};
    s_nxt.samp = {s_r.samp[1:0], s_r.sync[1]};
    if (!i_filter_en) begin
      s_nxt.level = s_r.sync[1];
    end else if (&s_r.samp || ~|s_r.samp) begin
      s_nxt.level = s_r.samp[0];
    end
    s_nxt.rise = s_nxt.level & ~s_r.level;
    s_nxt.fall = ~s_nxt.level & s_r.level;
  end
  // ==========================================================
  // state register
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign o_rise = s_r.rise;
  assign o_fall = s_r.fall;
endmodule : dccbs_in_cond
`default_nettype wire

// >>> core/dccbs_cnt_src.sv
// count source selector: prescaled clock, external edge or fast osc
`timescale 1ns/10ps
`default_nettype none
module dccbs_cnt_src (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic [2:0] i_src_sel,
  input wire logic [1:0] i_ext_edge,
  input wire logic i_ext_rise,
  input wire logic i_ext_fall,
  input wire logic i_fast_rise,
  output logic o_tick
);
  typedef struct packed {
    logic [4:0] pre;
    logic tick;
  } dccbs_src_t;
  dccbs_src_t s_r;
  dccbs_src_t s_nxt;
  // ==========================================================
  // prescaler and tick select
  always_comb begin
    s_nxt = s_r;
    s_nxt.pre = s_r.pre + 5'h01;
    case (i_src_sel)
      dccbs_pkg::SRC_DIV1: s_nxt.tick = 1'b1;
      dccbs_pkg::SRC_DIV2: s_nxt.tick = s_r.pre[0];
      dccbs_pkg::SRC_DIV4: s_nxt.tick = &s_r.pre[1:0];
      dccbs_pkg::SRC_DIV8: s_nxt.tick = &s_r.pre[2:0];
      dccbs_pkg::SRC_DIV32: s_nxt.tick = &s_r.pre;
      dccbs_pkg::SRC_EXT: begin
        s_nxt.tick = (i_ext_rise & i_ext_edge[0]) |
                     (i_ext_fall & i_ext_edge[1]);
      end
      dccbs_pkg::SRC_FAST: s_nxt.tick = i_fast_rise;
      default: s_nxt.tick = 1'b0;
    endcase
  end
  // ==========================================================
  // state register
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign o_tick = s_r.tick;
endmodule : dccbs_cnt_src
`default_nettype wire

// >>> core/dccbs_top.sv
// two-channel 16-bit capture timer with buffer and sync operation
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module dccbs_top (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic [7:0] i_capture_input_pin,
  input wire logic i_external_count_clock_pin,
  input wire logic i_fast_onchip_osc_clock,
  input wire logic i_slow_onchip_osc_trigger,
  output logic [1:0] o_ch_irq
);
  typedef struct packed {
    logic [1:0][15:0] cnt;
    logic [1:0][3:0][15:0] gr;
    logic [1:0][7:0] ctrl;
    logic [1:0][7:0] ioab;
    logic [1:0][7:0] iocd;
    logic [1:0][5:0] sts;
    logic [1:0][3:0] filt;
    logic [1:0] start;
    logic [1:0] csel;
    logic sync;
    logic [1:0] bfc;
    logic [1:0] bfd;
    logic [2:0] func;
    logic [15:0] rdata;
    logic [1:0] irq;
  } dccbs_state_t;
  dccbs_state_t s_r;
  dccbs_state_t s_nxt;
  // ==========================================================
  // input conditioning: 8 capture pins, ext clock, fast, slow
  logic [10:0] raw;
  logic [10:0] flt_en;
  logic [10:0] rise;
  logic [10:0] fall;
  logic [1:0] tick;
  assign raw = {i_slow_onchip_osc_trigger, i_fast_onchip_osc_clock,
                i_external_count_clock_pin, i_capture_input_pin};
  assign flt_en = {3'h0, s_r.filt[1], s_r.filt[0]};
  genvar g;
  generate
    for (g = 0; g < 11; g++) begin : g_in
      dccbs_in_cond u_cond (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_pin(raw[g]),
        .i_filter_en(flt_en[g]),
        .o_rise(rise[g]),
        .o_fall(fall[g])
      );
    end
    for (g = 0; g < 2; g++) begin : g_src
      dccbs_cnt_src u_src (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_src_sel(s_r.ctrl[g][dccbs_pkg::CTRL_SRC_LSB +: 3]),
        .i_ext_edge(s_r.ctrl[g][dccbs_pkg::CTRL_EDGE_LSB +: 2]),
        .i_ext_rise(rise[8]),
        .i_ext_fall(fall[8]),
        .i_fast_rise(rise[9]),
        .o_tick(tick[g])
      );
    end
  endgenerate
  // ==========================================================
  // event decode and next-state logic
  logic [1:0][3:0] io_cap;
  logic [1:0][3:0] capt;
  logic [1:0][3:0] mtch;
  logic [1:0] run;
  logic [1:0] own_clr;
  logic [1:0] clr;
  logic [1:0] down;
  logic [1:0] ovf;
  logic [1:0] udf;
  logic [1:0][7:0] cb;
  logic [3:0] io;
  logic pr;
  logic pf;
  logic xfer0;
  logic cnt_wr;
  always_comb begin
    s_nxt = s_r;
    s_nxt.irq = 2'h0;
    io = 4'h0;
    pr = 1'b0;
    pf = 1'b0;
    cnt_wr = 1'b0;
    for (int i = 0; i < 2; i++) begin
      cb[i] = i[0] ? dccbs_pkg::CH_STRIDE : 8'h00;
      run[i] = tick[i] & s_r.start[i];
      down[i] = (i == 1) &&
                (s_r.func == dccbs_pkg::FN_COMPL);
      for (int j = 0; j < 4; j++) begin
        io = (j < 2) ? s_r.ioab[i][j*4 +: 4]
                     : s_r.iocd[i][(j-2)*4 +: 4];
        pr = rise[i*4+j];
        pf = fall[i*4+j];
        if (i == 0 && j == 0 && io[dccbs_pkg::IO_AUX_BIT]) begin
          pr = rise[10];
          pf = fall[10];
        end
        io_cap[i][j] = io[dccbs_pkg::IO_CAP_BIT];
        capt[i][j] = io_cap[i][j] &
                     ((pr & io[0]) | (pf & io[1]));
        mtch[i][j] = ~io_cap[i][j] & run[i] &
                     (s_r.cnt[i] == s_r.gr[i][j]);
      end
      own_clr[i] = s_r.start[i] &
        (((s_r.ctrl[i][2:0] == dccbs_pkg::CLR_GRA) &
          (capt[i][0] | mtch[i][0])) |
         ((s_r.ctrl[i][2:0] == dccbs_pkg::CLR_GRB) &
          (capt[i][1] | mtch[i][1])));
      ovf[i] = run[i] & ~down[i] & (s_r.cnt[i] == dccbs_pkg::CNT_MAX);
      udf[i] = run[i] & down[i] & (s_r.cnt[i] == dccbs_pkg::RST_ZERO);
    end
    // sync clear follows the other channel's own clear
    clr[0] = own_clr[0] | (s_r.sync & own_clr[1] &
      (s_r.ctrl[0][2:0] == dccbs_pkg::CLR_SYNC));
    clr[1] = own_clr[1] | (s_r.sync & own_clr[0] &
      (s_r.ctrl[1][2:0] == dccbs_pkg::CLR_SYNC));
    xfer0 = run[0] & (s_r.cnt[0] == s_r.gr[0][0]);

    // software writes to configuration and general registers
    if (i_wr) begin
      for (int i = 0; i < 2; i++) begin
        if (i_addr == dccbs_pkg::OFS_CTRL + cb[i]) begin
          s_nxt.ctrl[i] = i_wdata[7:0];
        end
        if (i_addr == dccbs_pkg::OFS_IOAB + cb[i]) begin
          s_nxt.ioab[i] = i_wdata[7:0];
        end
        if (i_addr == dccbs_pkg::OFS_IOCD + cb[i]) begin
          s_nxt.iocd[i] = i_wdata[7:0];
        end
        if (i_addr == dccbs_pkg::OFS_STS + cb[i]) begin
          s_nxt.sts[i] = s_r.sts[i] & i_wdata[5:0]; // zero clears
        end
        if (i_addr == dccbs_pkg::OFS_FILT + cb[i]) begin
          s_nxt.filt[i] = i_wdata[3:0];
        end
        for (int j = 0; j < 4; j++) begin
          if (i_addr == dccbs_pkg::OFS_GRA + cb[i] + 8'(j)) begin
            s_nxt.gr[i][j] = i_wdata;
          end
        end
        if (i_addr == dccbs_pkg::OFS_CNT + cb[i]) begin
          cnt_wr = 1'b1;
        end
      end
      if (i_addr == dccbs_pkg::OFS_START) begin
        s_nxt.csel = i_wdata[dccbs_pkg::CSEL_LSB +: 2];
        for (int i = 0; i < 2; i++) begin
          if (i_wdata[i]) begin
            s_nxt.start[i] = 1'b1;
          end else if (i_wdata[dccbs_pkg::CSEL_LSB + i]) begin
            s_nxt.start[i] = 1'b0;
          end
        end
      end
      if (i_addr == dccbs_pkg::OFS_MODE) begin
        s_nxt.sync = i_wdata[0];
        s_nxt.bfc = i_wdata[dccbs_pkg::MODE_BFC_LSB +: 2];
        s_nxt.bfd = i_wdata[dccbs_pkg::MODE_BFD_LSB +: 2];
      end
      if (i_addr == dccbs_pkg::OFS_FUNC) begin
        s_nxt.func = i_wdata[2:0];
      end
    end

    // counters, captures, compare transfers and flags
    for (int i = 0; i < 2; i++) begin
      if (clr[i]) begin
        s_nxt.cnt[i] = dccbs_pkg::CLR_VALUE;
      end else if (run[i] && down[i]) begin
        s_nxt.cnt[i] = s_r.cnt[i] - 16'h0001;
      end else if (run[i]) begin
        s_nxt.cnt[i] = s_r.cnt[i] + 16'h0001;
      end
      if (cnt_wr && (s_r.sync ||
          i_addr == dccbs_pkg::OFS_CNT + cb[i])) begin
        s_nxt.cnt[i] = i_wdata;
      end
      for (int j = 0; j < 2; j++) begin
        // compare match reloads A/B from C/D in timer and pwm
        if (mtch[i][j] && (j == 0 ? s_r.bfc[i] : s_r.bfd[i]) &&
            (s_r.func == dccbs_pkg::FN_TIMER ||
             s_r.func == dccbs_pkg::FN_PWM)) begin
          s_nxt.gr[i][j] = s_r.gr[i][j+2];
        end
        if (capt[i][j]) begin
          if (j == 0 ? s_r.bfc[i] : s_r.bfd[i]) begin
            s_nxt.gr[i][j+2] = s_r.gr[i][j];
          end
          s_nxt.gr[i][j] = s_r.cnt[i];
        end
      end
      // C and D capture into themselves only when not buffers
      if (capt[i][2] && !s_r.bfc[i]) begin
        s_nxt.gr[i][2] = s_r.cnt[i];
      end
      if (capt[i][3] && !s_r.bfd[i]) begin
        s_nxt.gr[i][3] = s_r.cnt[i];
      end
      for (int j = 0; j < 4; j++) begin
        if (capt[i][j] || mtch[i][j]) begin
          s_nxt.sts[i][j] = 1'b1;
        end
      end
      if (capt[i][2] && s_r.bfc[i] && s_r.bfd[i]) begin
        s_nxt.sts[i][3:2] = 2'h3;
      end
      if (ovf[i]) begin
        s_nxt.sts[i][dccbs_pkg::STS_OVF_BIT] = 1'b1;
      end
      if (udf[i]) begin
        s_nxt.sts[i][dccbs_pkg::STS_UDF_BIT] = 1'b1;
      end
      s_nxt.irq[i] = (|capt[i]) | ovf[i];
    end

    // mode-wide buffer transfers
    case (s_r.func)
      dccbs_pkg::FN_RSYNC: begin
        for (int i = 0; i < 2; i++) begin
          if (xfer0 && s_r.bfc[i]) begin
            s_nxt.gr[i][0] = s_r.gr[i][2];
          end
          if (xfer0 && s_r.bfd[i]) begin
            s_nxt.gr[i][1] = s_r.gr[i][3];
          end
        end
      end
      dccbs_pkg::FN_COMPL: begin
        if ((xfer0 || udf[1]) && s_r.bfd[0]) begin
          s_nxt.gr[0][1] = s_r.gr[0][3];
        end
        if ((xfer0 || udf[1]) && s_r.bfc[1]) begin
          s_nxt.gr[1][0] = s_r.gr[1][2];
        end
        if ((xfer0 || udf[1]) && s_r.bfd[1]) begin
          s_nxt.gr[1][1] = s_r.gr[1][3];
        end
      end
      dccbs_pkg::FN_PWM3: begin
        for (int i = 0; i < 2; i++) begin
          if (xfer0 && s_r.bfc[i]) begin
            s_nxt.gr[i][0] = s_r.gr[i][2];
          end
          if (xfer0 && s_r.bfd[i]) begin
            s_nxt.gr[i][1] = s_r.gr[i][3];
          end
        end
      end
      default: begin
      end
    endcase

    // read data, valid in the cycle after the strobe only
    s_nxt.rdata = dccbs_pkg::RST_ZERO;
    if (i_rd) begin
      for (int i = 0; i < 2; i++) begin
        if (i_addr == dccbs_pkg::OFS_CTRL + cb[i]) begin
          s_nxt.rdata = {8'h00, s_r.ctrl[i]};
        end
        if (i_addr == dccbs_pkg::OFS_IOAB + cb[i]) begin
          s_nxt.rdata = {8'h00, s_r.ioab[i]};
        end
        if (i_addr == dccbs_pkg::OFS_IOCD + cb[i]) begin
          s_nxt.rdata = {8'h00, s_r.iocd[i]};
        end
        if (i_addr == dccbs_pkg::OFS_STS + cb[i]) begin
          s_nxt.rdata = {10'h000, s_r.sts[i]};
        end
        if (i_addr == dccbs_pkg::OFS_CNT + cb[i]) begin
          s_nxt.rdata = s_r.cnt[i];
        end
        if (i_addr == dccbs_pkg::OFS_FILT + cb[i]) begin
          s_nxt.rdata = {12'h000, s_r.filt[i]};
        end
        for (int j = 0; j < 4; j++) begin
          if (i_addr == dccbs_pkg::OFS_GRA + cb[i] + 8'(j)) begin
            s_nxt.rdata = s_r.gr[i][j];
          end
        end
      end
      if (i_addr == dccbs_pkg::OFS_START) begin
        s_nxt.rdata = {12'h000, s_r.csel, s_r.start};
      end
      if (i_addr == dccbs_pkg::OFS_MODE) begin
        s_nxt.rdata = {11'h000, s_r.bfd, s_r.bfc, s_r.sync};
      end
      if (i_addr == dccbs_pkg::OFS_FUNC) begin
        s_nxt.rdata = {13'h0000, s_r.func};
      end
    end
  end
  // ==========================================================
  // state register
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign o_rdata = s_r.rdata;
  assign o_ch_irq = s_r.irq;
endmodule : dccbs_top
`default_nettype wire

// >>> bench/dccbs_pin_model.sv
// model of the signals that drive the capture and count clock pins
`timescale 1ns/10ps
`default_nettype none
module dccbs_pin_model (
  input wire logic i_core_clk,
  output logic [7:0] o_pins,
  output logic o_ext_clk,
  output logic o_fast_clk,
  output logic o_slow_trig
);
  // ==========================================================
  // pin levels: 0..7 capture pins, 8 ext clock, 9 fast osc, 10 slow osc
  logic [10:0] lv_r;
  initial lv_r = 11'h000;
  assign o_pins = lv_r[7:0];
  assign o_ext_clk = lv_r[8];
  assign o_fast_clk = lv_r[9];
  assign o_slow_trig = lv_r[10];
  // ==========================================================
  // drive one line to a level and hold it for w core cycles
  task automatic lvl(input int idx, input logic v, input int w);
    @(posedge i_core_clk);
    lv_r[idx] <= v;
    repeat (w - 1) @(posedge i_core_clk);
  endtask : lvl
  // n clock pulses, high and low four cycles each; idle low between
  task automatic pulses(input int idx, input int n);
    repeat (n) begin
      lvl(idx, 1'b1, 4);
      lvl(idx, 1'b0, 4);
    end
  endtask : pulses
endmodule : dccbs_pin_model
`default_nettype wire

// >>> bench/dccbs_chk.sv
// assertion checker on the ports of the capture timer top
`timescale 1ns/10ps
`default_nettype none
module dccbs_chk (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic [7:0] i_capture_input_pin,
  input wire logic i_external_count_clock_pin,
  input wire logic i_fast_onchip_osc_clock,
  input wire logic i_slow_onchip_osc_trigger,
  input wire logic [1:0] o_ch_irq
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);
  // ==========================================================
  // a stored field reads back what was written two cycles before
  property p_rb(a, m);
    (i_wr && i_addr == a) ##1 !i_wr ##1 (i_rd && i_addr == a)
      |=> (o_rdata & m) == ($past(i_wdata, 3) & m);
  endproperty
  // ==========================================================
  // register bus and reset behaviour
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data not zero outside read answer");
  a_reset_quiet: assert property ($past(i_sys_rst)
    |-> o_ch_irq == 2'b00 && o_rdata == 16'h0000)
    else $error("outputs not cleared by reset");
  a_quiet_after_rst: assert property ($fell(i_sys_rst)
    |-> (o_ch_irq == 2'b00) [*2])
    else $error("interrupt right after reset release");
  a_unmapped_read: assert property (i_rd && i_addr == 8'hff
    |=> o_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_start_readback: assert property ((i_wr && i_addr == 8'h20 &&
    i_wdata[3:2] == 2'b11) ##1 !i_wr ##1 (i_rd && i_addr == 8'h20)
    |=> o_rdata[3:0] == $past(i_wdata[3:0], 3))
    else $error("start register readback wrong");
  a_mode_readback: assert property (p_rb(8'h21, 16'h001f))
    else $error("mode register readback wrong");
  a_ioab_readback: assert property (p_rb(8'h01, 16'h00ff))
    else $error("io ab register readback wrong");
  a_iocd_readback: assert property (p_rb(8'h02, 16'h00ff))
    else $error("io cd register readback wrong");
  // ==========================================================
  // main scenarios reached
  c_irq_ch0: cover property (o_ch_irq[0]);
  c_cnt_read: cover property (i_rd && i_addr == 8'h04);
  c_sync_on: cover property (i_wr && i_addr == 8'h21 && i_wdata[0]);
endmodule : dccbs_chk
bind dccbs_top dccbs_chk u_chk (
  .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_capture_input_pin(i_capture_input_pin),
  .i_external_count_clock_pin(i_external_count_clock_pin),
  .i_fast_onchip_osc_clock(i_fast_onchip_osc_clock),
  .i_slow_onchip_osc_trigger(i_slow_onchip_osc_trigger),
  .o_ch_irq(o_ch_irq)
);
`default_nettype wire

// >>> bench/dccbs_tb_top.sv
// self-checking testbench of the two-channel capture timer
`timescale 1ns/10ps
`default_nettype none
module dccbs_tb_top;
  logic i_core_clk;
  logic i_sys_rst;
  logic [7:0] i_addr;
  logic [15:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic [15:0] o_rdata;
  logic [7:0] pins;
  logic ext_clk;
  logic fast_clk;
  logic slow_trig;
  logic [1:0] o_ch_irq;
  logic [15:0] v0;
  logic [15:0] v1;
  int failures = 0;
  int total_checks = 0;
  int irq0 = 0;
  int irq1 = 0;
  int n;
  // ==========================================================
  // design and pin model
  dccbs_top u_dut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_capture_input_pin(pins),
    .i_external_count_clock_pin(ext_clk),
    .i_fast_onchip_osc_clock(fast_clk),
    .i_slow_onchip_osc_trigger(slow_trig), .o_ch_irq(o_ch_irq));
  dccbs_pin_model u_pm (.i_core_clk(i_core_clk), .o_pins(pins),
    .o_ext_clk(ext_clk), .o_fast_clk(fast_clk), .o_slow_trig(slow_trig));
  // 20 MHz core clock
  initial begin
    i_core_clk = 1'b0;
    forever #25 i_core_clk = ~i_core_clk;
  end
  // count interrupt pulses of each channel
  always @(posedge i_core_clk) begin
    if (o_ch_irq[0] === 1'b1) irq0 <= irq0 + 1;
    if (o_ch_irq[1] === 1'b1) irq1 <= irq1 + 1;
  end
  // ==========================================================
  // bus and compare helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] v;
    rd(a, v);
    chk(v, exp);
  endtask : rdc
  // two counter reads 64 cycles apart into v0 and v1
  task automatic gap;
    rd(8'h04, v0);
    repeat (62) @(posedge i_core_clk);
    rd(8'h04, v1);
  endtask : gap
  // ==========================================================
  // scenarios
  task automatic t_reset;
    rdc(8'h04, 16'h0000);
    rdc(8'h03, 16'h0000);
    wr(8'hff, 16'hffff);
    rdc(8'hff, 16'h0000);
    wr(8'h01, 16'h0099);
    rdc(8'h01, 16'h0099);
    wr(8'h02, 16'h009a);
    rdc(8'h02, 16'h009a);
    wr(8'h21, 16'h001e);
    rdc(8'h21, 16'h001e);
    wr(8'h21, 16'h0000);
    wr(8'h20, 16'h000c);
    rdc(8'h20, 16'h000c);
  endtask : t_reset
  task automatic t_src;
    for (int k = 0; k < 5; k++) begin
      wr(8'h00, 16'(k << 3));
      wr(8'h20, 16'h0005);
      gap();
      chk(16'(v1 - v0), 16'(64 >> ((k == 4) ? 5 : k)));
      wr(8'h20, 16'h0004);
    end
    gap();
    chk(16'(v1 - v0), 16'h0000);
    wr(8'h00, 16'h0000);
    wr(8'h20, 16'h0001);
    wr(8'h20, 16'h0000);
    gap();
    chk(16'(v1 - v0), 16'h0040);
    for (int k = 0; k < 3; k++) begin
      wr(8'h00, (k == 0) ? 16'h0068 : (k == 1) ? 16'h00e8 : 16'h0030);
      wr(8'h20, 16'h0005);
      rd(8'h04, v0);
      u_pm.pulses((k == 2) ? 9 : 8, 3);
      repeat (8) @(posedge i_core_clk);
      rd(8'h04, v1);
      chk(16'(v1 - v0), (k == 1) ? 16'h0006 : 16'h0003);
      wr(8'h20, 16'h0004);
    end
    wr(8'h00, 16'h0000);
    wr(8'h04, 16'hfffd);
    n = irq0;
    wr(8'h20, 16'h0005);
    repeat (10) @(posedge i_core_clk);
    wr(8'h20, 16'h0004);
    rd(8'h04, v0);
    chk(16'(irq0 - n), 16'h0001);
    chk(16'(v0 < 16'h0010), 16'h0001);
  endtask : t_src
  task automatic t_sync;
    wr(8'h21, 16'h0001);
    wr(8'h14, 16'h1234);
    rdc(8'h04, 16'h1234);
    for (int c = 0; c < 2; c++) begin
      wr(8'(16 * c), 16'h0003);
      wr(8'(16 - 16 * c), 16'h0001);
      wr(8'(21 - 16 * c), 16'h0010);
      wr(8'h04, 16'h0000);
      wr(8'h20, 16'h0003);
      repeat (40) @(posedge i_core_clk);
      rd(8'(16 * c + 4), v0);
      rd(8'(20 - 16 * c), v1);
      chk(v1, 16'((int'(v0) + 2) % 17));
      wr(8'h20, 16'h000c);
    end
    wr(8'h21, 16'h0000);
  endtask : t_sync
  task automatic t_cap;
    wr(8'h00, 16'h0000);
    wr(8'h04, 16'h0abc);
    n = irq0;
    wr(8'h01, 16'h0005);
    u_pm.lvl(0, 1'b1, 8);
    rdc(8'h05, 16'h0abc);
    wr(8'h04, 16'h0def);
    u_pm.lvl(0, 1'b0, 8);
    rdc(8'h05, 16'h0abc);
    wr(8'h01, 16'h0006);
    u_pm.lvl(0, 1'b1, 8);
    u_pm.lvl(0, 1'b0, 8);
    rdc(8'h05, 16'h0def);
    chk(16'(irq0 - n), 16'h0002);
    wr(8'h21, 16'h0002);
    wr(8'h02, 16'h000c);
    wr(8'h01, 16'h0017);
    wr(8'h04, 16'h0111);
    u_pm.lvl(0, 1'b1, 8);
    rdc(8'h05, 16'h0111);
    rdc(8'h07, 16'h0def);
    u_pm.lvl(1, 1'b1, 8);
    rdc(8'h06, 16'h0000);
    wr(8'h21, 16'h000a);
    wr(8'h01, 16'h0057);
    wr(8'h02, 16'h00dd);
    wr(8'h03, 16'h0000);
    u_pm.lvl(2, 1'b1, 8);
    rd(8'h03, v0);
    chk(v0 & 16'h000c, 16'h000c);
    wr(8'h21, 16'h0000);
    wr(8'h01, 16'h000d);
    wr(8'h04, 16'h0222);
    u_pm.lvl(10, 1'b1, 8);
    rdc(8'h05, 16'h0222);
    wr(8'h01, 16'h0005);
    u_pm.lvl(0, 1'b0, 8);
    wr(8'h09, 16'h0001);
    wr(8'h04, 16'h0333);
    n = irq0;
    u_pm.lvl(0, 1'b1, 2);
    u_pm.lvl(0, 1'b0, 8);
    chk(16'(irq0 - n), 16'h0000);
    u_pm.lvl(0, 1'b1, 10);
    rdc(8'h05, 16'h0333);
    n = irq1;
    wr(8'h11, 16'h0005);
    wr(8'h14, 16'h0444);
    u_pm.lvl(4, 1'b1, 8);
    rdc(8'h15, 16'h0444);
    chk(16'(irq1 - n), 16'h0001);
  endtask : t_cap
  task automatic t_buf;
    for (int f = 0; f < 5; f++) begin
      wr(8'h22, 16'(f));
      wr(8'h01, 16'h0000);
      wr(8'h02, 16'h0088);
      wr(8'h21, 16'h000a);
      wr(8'h05, 16'h0008);
      wr(8'h06, 16'h0009);
      wr(8'h07, 16'h0030);
      wr(8'h08, 16'h0031);
      wr(8'h04, 16'h0000);
      wr(8'h20, 16'h0005);
      repeat (30) @(posedge i_core_clk);
      wr(8'h20, 16'h0004);
      rdc(8'h05, (f == 3) ? 16'h0008 : 16'h0030);
      rdc(8'h06, 16'h0031);
    end
  endtask : t_buf
  // ==========================================================
  // verdict and end of run
  task automatic complete_run;
    if (failures == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge i_core_clk);
    failures++;
    complete_run();
  end
  // main sequence
  initial begin
    i_sys_rst = 1'b1;
    i_addr = 8'h00;
    i_wdata = 16'h0000;
    i_wr = 1'b0;
    i_rd = 1'b0;
    repeat (6) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    t_reset();
    t_src();
    t_sync();
    t_cap();
    t_buf();
    complete_run();
  end
endmodule : dccbs_tb_top
`default_nettype wire
